// >>> pkg/led_guard_pkg.sv
/*
 * Shared constants, register map and field carriers of the LED fault and
 * protection controller. Assumes a 32-bit Avalon-MM word-addressed slave.
 */
package led_guard_pkg;

	localparam int CHANNELS   = 16;
	localparam int GROUPS     = 4;
	localparam int HALF_BANK  = 8;
	localparam int ADDR_W     = 3;
	localparam int DATA_W     = 32;
	localparam int CNT_W      = 8;
	localparam int CUR_W      = 3;
	localparam int LAT_W      = 2;
	localparam int PS_W       = 3;

	// Register word indices
	localparam logic [ADDR_W-1:0] REG_CTRL   = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 3'h1;
	localparam logic [ADDR_W-1:0] REG_DETECT = 3'h2;
	localparam logic [ADDR_W-1:0] REG_LEAK   = 3'h3;

	// Control field positions
	localparam int CTRL_IDM_BIT = 0;
	localparam int CTRL_CUR_LSB = 1;
	localparam int CTRL_LAT_LSB = 4;
	localparam int CTRL_PS_LSB  = 6;
	localparam int CTRL_BITS    = 9;

	// Status field positions
	localparam int ST_REF_BIT  = 0;
	localparam int ST_WARN_BIT = 1;
	localparam int ST_TERR_BIT = 2;
	localparam int ST_PS_BIT   = 3;
	localparam int ST_IDM_BIT  = 4;
	localparam int ST_TSD_BIT  = 5;

	// Detection field positions
	localparam int DET_OPEN_LSB  = 0;
	localparam int DET_SHORT_LSB = 16;

	// Power-save low-bit codes
	localparam logic [1:0] PS_OFF  = 2'h0;
	localparam logic [1:0] PS_AUTO = 2'h1;
	localparam logic [1:0] PS_ALT  = 2'h2;

	// Reset values
	localparam logic [CUR_W-1:0] CUR_RESET = 3'h0;
	localparam logic [LAT_W-1:0] LAT_RESET = 2'h0;
	localparam logic [PS_W-1:0]  PS_RESET  = 3'h0;

	// Pwm clock counts at which detection results are latched, per code
	localparam logic [CNT_W-1:0] LAT_COUNT_0 = 8'h02;
	localparam logic [CNT_W-1:0] LAT_COUNT_1 = 8'h22;
	localparam logic [CNT_W-1:0] LAT_COUNT_2 = 8'h42;
	localparam logic [CNT_W-1:0] LAT_COUNT_3 = 8'h82;

	// Group stagger delay
	localparam int GROUP_DELAY_NS = 100;
	localparam int CLK_PERIOD_NS  = 50;
	localparam int GROUP_DELAY_CYC =
		(GROUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(GROUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [PS_W-1:0]  ps_field;
		logic [LAT_W-1:0] latch_timing;
		logic [CUR_W-1:0] current_select;
		logic             idm_enable;
	} ctrl_t;

	typedef struct packed {
		logic tsd_latched;
		logic idm_active;
		logic power_save;
		logic thermal_error;
		logic thermal_warning;
		logic reference_short;
	} status_t;

	typedef struct packed {
		logic serial_clk;
		logic pwm_clk;
		logic load_strobe;
		logic ref_short;
		logic temp_warn;
		logic temp_over;
		logic temp_cool;
	} pin_t;

endpackage

// >>> rtl/led_guard.sv
/*
 * LED fault detection and protection controller: detection sampling,
 * result latching, power save, reference short, thermal warning and
 * shutdown, and staggered group switching of 16 sinks.
 * Assumes the pwm count logic on clk_sys_in supplies per-channel on
 * levels, a display-period start pulse and a zero-grayscale-write pulse;
 * link pins and comparator levels arrive asynchronously.
 */
`timescale 1ns/1ns

module led_guard
	import led_guard_pkg::*;
#(
	parameter int GROUP_DELAY = GROUP_DELAY_CYC
)
(
	// Clock, reset, enable
	input  wire logic                clk_sys_in,
	input  wire logic                arst_n_in,
	input  wire logic                ce_in,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0]   avs_address_in,
	input  wire logic                avs_read_in,
	input  wire logic                avs_write_in,
	input  wire logic [DATA_W-1:0]   avs_writedata_in,
	output logic      [DATA_W-1:0]   avs_readdata_out,
	output logic                     avs_waitrequest_out,
	// Link pins
	input  wire logic                serial_clock_in,
	input  wire logic                pwm_count_clock_in,
	input  wire logic                load_strobe_in,
	// Same-clock pwm logic
	input  wire logic [CHANNELS-1:0] grayscale_on_in,
	input  wire logic                period_start_in,
	input  wire logic                grayscale_zero_write_in,
	input  wire logic                grayscale_load_in,
	// Analog comparators
	input  wire logic [CHANNELS-1:0] open_cmp_in,
	input  wire logic [CHANNELS-1:0] short_cmp_in,
	input  wire logic [CHANNELS-1:0] leak_high_cmp_in,
	input  wire logic                reference_current_pin_short_in,
	input  wire logic                temp_warn_in,
	input  wire logic                temp_over_in,
	input  wire logic                temp_cool_in,
	// Sink drive
	output logic      [CHANNELS-1:0] sink_output_out,
	output logic      [CHANNELS-1:0] detect_sink_out,
	output logic      [CUR_W-1:0]    detection_current_select_out,
	output logic      [CHANNELS-1:0] leak_source_out,
	// Status
	output logic                     power_save_state_out,
	output logic                     reference_short_flag_out,
	output logic                     thermal_warning_flag_out,
	output logic                     thermal_error_flag_out,
	output logic      [CHANNELS-1:0] open_led_flag_out,
	output logic      [CHANNELS-1:0] shorted_led_flag_out,
	output logic      [CHANNELS-1:0] output_leakage_flag_out
);

	localparam int PIN_W  = $bits(pin_t);
	localparam int SYNC_W = PIN_W + 3 * CHANNELS;
	localparam int TAPS   = (GROUPS - 1) * GROUP_DELAY + 1;

	// Reset release
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Three-stage input synchronisers
	pin_t              pins_raw;
	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_1;
	logic [SYNC_W-1:0] sync_2;
	logic [SYNC_W-1:0] sync_3;
	logic [SYNC_W-1:0] sync_val;
	logic [SYNC_W-1:0] next_sync_val;

	assign pins_raw = '{serial_clk: serial_clock_in, pwm_clk: pwm_count_clock_in,
		load_strobe: load_strobe_in, ref_short: reference_current_pin_short_in,
		temp_warn: temp_warn_in, temp_over: temp_over_in, temp_cool: temp_cool_in};
	assign sync_raw = {leak_high_cmp_in, short_cmp_in, open_cmp_in, pins_raw};
	assign next_sync_val = (sync_val & (sync_2 ^ sync_3)) | (sync_2 & ~(sync_2 ^ sync_3));

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_1   <= '0;
			sync_2   <= '0;
			sync_3   <= '0;
			sync_val <= '0;
		end
		else if (ce_in)
		begin
			sync_1   <= sync_raw;
			sync_2   <= sync_1;
			sync_3   <= sync_2;
			sync_val <= next_sync_val;
		end
	end

	pin_t              pins_now;
	pin_t              pins_old;
	logic [CHANNELS-1:0] open_now;
	logic [CHANNELS-1:0] short_now;
	logic [CHANNELS-1:0] leak_high_now;

	assign pins_now      = pin_t'(sync_val[PIN_W-1:0]);
	assign pins_old      = pin_t'(next_sync_val[PIN_W-1:0]);
	assign open_now      = sync_val[PIN_W +: CHANNELS];
	assign short_now     = sync_val[PIN_W + CHANNELS +: CHANNELS];
	assign leak_high_now = sync_val[PIN_W + 2 * CHANNELS +: CHANNELS];

	// Edge detection on the filtered copy
	wire serial_rise = pins_old.serial_clk & ~pins_now.serial_clk;
	wire pwm_rise    = pins_old.pwm_clk & ~pins_now.pwm_clk;
	wire strobe_rise = pins_old.load_strobe & ~pins_now.load_strobe;
	wire gs_strobe   = strobe_rise & grayscale_load_in;

	// Avalon-MM slave, one wait cycle per access
	ctrl_t             ctrl;
	status_t           status;
	logic              ack;
	logic [DATA_W-1:0] read_mux;

	wire req        = avs_read_in | avs_write_in;
	wire wr_take    = avs_write_in & ack;
	wire sel_ctrl   = avs_address_in == REG_CTRL;
	wire sel_status = avs_address_in == REG_STATUS;
	wire sel_detect = avs_address_in == REG_DETECT;
	wire sel_leak   = avs_address_in == REG_LEAK;

	assign read_mux =
		sel_ctrl   ? DATA_W'({ctrl}) :
		sel_status ? DATA_W'({status}) :
		sel_detect ? {shorted_led_flag_out, open_led_flag_out} :
		sel_leak   ? DATA_W'(output_leakage_flag_out) :
		'0;

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack                 <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= '0;
		end
		else if (ce_in)
		begin
			ack                 <= req & ~ack;
			avs_waitrequest_out <= ~(req & ~ack);
			if (avs_read_in & ~ack)
				avs_readdata_out <= read_mux;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			ctrl <= '{ps_field: PS_RESET, latch_timing: LAT_RESET,
				current_select: CUR_RESET, idm_enable: 1'b0};
		else if (ce_in && wr_take && sel_ctrl)
			ctrl <= ctrl_t'(avs_writedata_in[CTRL_BITS-1:0]);
	end

	// Power save
	logic       power_save_state;
	logic       hold_off;
	wire  [1:0] ps_low     = ctrl.ps_field[1:0];
	wire        ps_allowed = ps_low != PS_OFF;
	wire        ps_enter   = grayscale_zero_write_in &
		(ps_low == PS_AUTO || ps_low == PS_ALT);
	wire        ps_exit    = power_save_state & serial_rise & (ps_low == PS_AUTO);

	// Thermal protection and reference short
	logic tsd_latched;
	logic warn_flag;
	logic terr_flag;
	logic ref_flag;

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_save_state         <= 1'b0;
			hold_off    <= 1'b0;
			tsd_latched <= 1'b0;
			warn_flag   <= 1'b0;
			terr_flag   <= 1'b0;
			ref_flag    <= 1'b0;
		end
		else if (ce_in)
		begin
			power_save_state <= ps_allowed & ~ps_exit & (power_save_state | ps_enter);
			// Outputs wait for a fresh period after exit or shutdown
			if (ps_exit || pins_now.temp_over)
				hold_off <= 1'b1;
			else if (period_start_in && !tsd_latched)
				hold_off <= 1'b0;
			if (pins_now.temp_over)
				tsd_latched <= 1'b1;
			else if (period_start_in && pins_now.temp_cool)
				tsd_latched <= 1'b0;
			// Set wins over clear
			warn_flag <= pins_now.temp_warn |
				(warn_flag & ~gs_strobe);
			terr_flag <= pins_now.temp_over |
				(terr_flag & ~(gs_strobe & pins_now.temp_cool));
			ref_flag  <= pins_now.ref_short;
		end
	end

	wire forced_off = ref_flag | tsd_latched | pins_now.temp_over | power_save_state | hold_off;

	// Pwm clock count within the display period
	logic [CNT_W-1:0] pwm_count;
	logic [CNT_W-1:0] latch_count;
	logic             idm_active;

	assign latch_count =
		ctrl.latch_timing == 2'h0 ? LAT_COUNT_0 :
		ctrl.latch_timing == 2'h1 ? LAT_COUNT_1 :
		ctrl.latch_timing == 2'h2 ? LAT_COUNT_2 :
		LAT_COUNT_3;

	wire count_full = pwm_count == '1;
	wire latch_now  = pwm_rise & ~count_full &
		(pwm_count + CNT_W'(1) == latch_count);
	wire idm_go     = ctrl.idm_enable & ~power_save_state;
	wire idm_start  = idm_go & pwm_rise & (pwm_count == '0);

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwm_count  <= '0;
			idm_active <= 1'b0;
		end
		else if (ce_in)
		begin
			if (period_start_in)
				pwm_count <= '0;
			else if (pwm_rise && !count_full)
				pwm_count <= pwm_count + CNT_W'(1);
			if (period_start_in || !idm_go || latch_now)
				idm_active <= 1'b0;
			else if (idm_start)
				idm_active <= 1'b1;
		end
	end

	// Result latches; held until the next capture
	logic [CHANNELS-1:0] leak_src;
	wire  [CHANNELS-1:0] sensed_on = grayscale_on_in | {CHANNELS{idm_active}};
	wire  leak_capture = period_start_in & ~ctrl.idm_enable;

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			open_led_flag_out       <= '0;
			shorted_led_flag_out    <= '0;
			output_leakage_flag_out <= '0;
		end
		else if (ce_in)
		begin
			if (latch_now && (idm_active || !ctrl.idm_enable))
			begin
				open_led_flag_out    <= open_now & sensed_on;
				shorted_led_flag_out <= short_now & sensed_on;
			end
			if (leak_capture)
				output_leakage_flag_out <= leak_src & ~leak_high_now;
		end
	end

	// Group stagger delay line
	logic [CHANNELS-1:0] tap [TAPS];
	wire  [CHANNELS-1:0] gated_on = grayscale_on_in & {CHANNELS{~forced_off}};

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < TAPS; i++)
				tap[i] <= '0;
		end
		else if (ce_in)
		begin
			tap[0] <= gated_on;
			for (int i = 1; i < TAPS; i++)
				tap[i] <= tap[i-1];
		end
	end

	logic [CHANNELS-1:0] next_sink;
	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++)
		begin : g_ch
			localparam int POS = c % HALF_BANK;
			localparam int GRP = POS < GROUPS ? POS : HALF_BANK - 1 - POS;
			// Forced off acts at once on every group
			assign next_sink[c] = tap[GRP * GROUP_DELAY][c] & ~forced_off;
		end
	endgenerate

	assign leak_src = ~grayscale_on_in & {CHANNELS{~ctrl.idm_enable & ~idm_active & ~power_save_state}};

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sink_output_out              <= '0;
			detect_sink_out              <= '0;
			detection_current_select_out <= CUR_RESET;
			leak_source_out              <= '0;
			power_save_state_out         <= 1'b0;
			reference_short_flag_out     <= 1'b0;
			thermal_warning_flag_out     <= 1'b0;
			thermal_error_flag_out       <= 1'b0;
			status                       <= '0;
		end
		else if (ce_in)
		begin
			sink_output_out              <= next_sink;
			detect_sink_out              <= {CHANNELS{idm_active & ~forced_off}};
			detection_current_select_out <= ctrl.current_select;
			leak_source_out              <= leak_src & {CHANNELS{~forced_off}};
			power_save_state_out         <= power_save_state;
			reference_short_flag_out     <= ref_flag;
			thermal_warning_flag_out     <= warn_flag;
			thermal_error_flag_out       <= terr_flag;
			status <= '{tsd_latched: tsd_latched, idm_active: idm_active,
				power_save: power_save_state, thermal_error: terr_flag,
				thermal_warning: warn_flag, reference_short: ref_flag};
		end
	end

endmodule

// >>> bench/led_guard_chk.sv
/* Port checker for led_guard.
   Assumes the bench drives one grayscale level on all channels. */
`timescale 1ns/1ns
module led_guard_chk
	import led_guard_pkg::*;
(
	// Clock, reset
	input wire logic                clk_sys_in,
	input wire logic                arst_n_in,
	// Inputs
	input wire logic                avs_read_in,
	input wire logic                avs_write_in,
	input wire logic                grayscale_load_in,
	// Outputs
	input wire logic                avs_waitrequest_out,
	input wire logic [CHANNELS-1:0] sink_output_out,
	input wire logic [CHANNELS-1:0] detect_sink_out,
	input wire logic [CHANNELS-1:0] leak_source_out,
	input wire logic                power_save_state_out,
	input wire logic                reference_short_flag_out,
	input wire logic                thermal_error_flag_out
);
	wire logic [7:0] mirror_low;
	wire logic       req;

	assign mirror_low = {<<{sink_output_out[7:0]}};
	assign req = avs_read_in || avs_write_in;

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);

	a_ref_force: assert property (
		reference_short_flag_out && $past(reference_short_flag_out, 3) |-> sink_output_out == '0)
		else $error("sinks on during reference short");
	a_terr_force: assert property (
		thermal_error_flag_out && $past(thermal_error_flag_out, 3) |-> sink_output_out == '0)
		else $error("sinks on during thermal error");
	a_ps_quiet: assert property (
		power_save_state_out && $past(power_save_state_out, 3) |-> detect_sink_out == '0)
		else $error("detection current in power save");
	a_leak_off: assert property (
		|detect_sink_out |-> leak_source_out == '0)
		else $error("leak source on during detection");
	a_group_same: assert property (
		sink_output_out[7:0] == mirror_low && sink_output_out[15:8] == sink_output_out[7:0])
		else $error("group members differ");
	a_terr_clear: assert property (
		$fell(thermal_error_flag_out) |-> $past(grayscale_load_in, 2))
		else $error("error flag cleared without grayscale load");
	a_one_wait: assert property (
		$fell(avs_waitrequest_out) |-> ##1 avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_bus_answer: assert property (
		req && avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out)
		else $error("bus answer late");
endmodule

bind led_guard led_guard_chk u_chk (.*);

// >>> bench/led_host_model.sv
/* Host link model: pwm count clock, serial clock and load strobe.
   Assumes one task at a time; all lines idle low between frames. */
`timescale 1ns/1ns
module led_host_model
(
	// Link pins
	output logic serial_clock_out,
	output logic pwm_count_clock_out,
	output logic load_strobe_out
);
	initial
	begin
		serial_clock_out = 1'b0;
		pwm_count_clock_out = 1'b0;
		load_strobe_out = 1'b0;
	end

	// Bench sizes bursts to stop one short of, then pass, the latch count
	task automatic pwm_burst(input int n);
		#10;
		repeat (n)
		begin
			#200 pwm_count_clock_out = 1'b1;
			#200 pwm_count_clock_out = 1'b0;
		end
	endtask

	task automatic sclk_edge();
		#10;
		#200 serial_clock_out = 1'b1;
		#200 serial_clock_out = 1'b0;
	endtask

	task automatic strobe();
		#10;
		#200 load_strobe_out = 1'b1;
		#200 load_strobe_out = 1'b0;
	endtask
endmodule

// >>> bench/tb_led_guard.sv
/* Self-checking bench for led_guard with the host link model.
   Assumes one bus wait state and the package constants. */
`timescale 1ns/1ns
module tb_led_guard
	import led_guard_pkg::*;
;
	logic                clk_sys_in, arst_n_in, ce_in, avs_read_in, avs_write_in;
	logic [ADDR_W-1:0]   avs_address_in;
	logic [DATA_W-1:0]   avs_writedata_in, avs_readdata_out;
	logic                avs_waitrequest_out, serial_clock_in, pwm_count_clock_in;
	logic                load_strobe_in, period_start_in, grayscale_zero_write_in;
	logic                grayscale_load_in, reference_current_pin_short_in, temp_warn_in;
	logic                temp_over_in, temp_cool_in, power_save_state_out;
	logic [CHANNELS-1:0] grayscale_on_in, open_cmp_in, short_cmp_in, leak_high_cmp_in;
	logic [CHANNELS-1:0] sink_output_out, detect_sink_out, leak_source_out;
	logic [CUR_W-1:0]    detection_current_select_out;
	logic                reference_short_flag_out, thermal_warning_flag_out;
	logic                thermal_error_flag_out;
	logic [CHANNELS-1:0] open_led_flag_out, shorted_led_flag_out, output_leakage_flag_out;
	logic [63:0]         notes[$];
	logic [31:0]         seed, r;
	logic [CNT_W-1:0]    lc[4];
	int                  miscompares = 0;
	int                  n_tests = 0;
	int                  n;

	led_guard #(.GROUP_DELAY(2)) DUT (.*);
	led_host_model host (
		.serial_clock_out    (serial_clock_in),
		.pwm_count_clock_out (pwm_count_clock_in),
		.load_strobe_out     (load_strobe_in)
	);

	initial
	begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (notes.size() != 0)
		begin
			miscompares++;
			$display("BAD %0t reads left unchecked", $time);
		end
		$display("Checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_in);
	endtask

	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int w;
		w = 0;
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do
		begin
			@(posedge clk_sys_in);
			w++;
		end
		while (avs_waitrequest_out !== 1'b0 && w < 20);
		if (w == 20)
		begin
			miscompares++;
			end_of_test();
		end
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back({m, e & m});
		bus(1'b0, a, 32'h0);
	endtask

	// Status with the detection and shutdown bits masked
	task automatic st(input logic [31:0] e);
		cyc(10);
		rd(REG_STATUS, e, 32'h0000000f);
	endtask

	task automatic new_period();
		period_start_in <= 1'b1;
		cyc(1);
		period_start_in <= 1'b0;
		cyc(1);
	endtask

	task automatic strobe(input logic gs);
		grayscale_load_in <= gs;
		host.strobe();
		cyc(10);
		grayscale_load_in <= 1'b0;
		cyc(1);
	endtask

	always @(posedge clk_sys_in)
		if (avs_read_in && avs_waitrequest_out === 1'b0 && notes.size() > 0)
		begin
			check(avs_readdata_out & notes[0][63:32], notes[0][31:0]);
			void'(notes.pop_front());
		end

	initial
	begin
		arst_n_in = 1'b0;
		ce_in = 1'b1;
		{avs_read_in, avs_write_in, period_start_in, grayscale_zero_write_in} = '0;
		{grayscale_load_in, reference_current_pin_short_in, temp_warn_in} = '0;
		{temp_over_in, temp_cool_in, avs_address_in, avs_writedata_in} = '0;
		{grayscale_on_in, open_cmp_in, short_cmp_in, leak_high_cmp_in} = '0;
		seed = 32'h000126be;
		lc = '{LAT_COUNT_0, LAT_COUNT_1, LAT_COUNT_2, LAT_COUNT_3};
		cyc(4);
		arst_n_in <= 1'b1;
		cyc(4);
		rd(REG_CTRL, 32'h0, '1);
		bus(1'b1, REG_DETECT, '1);
		rd(REG_DETECT, 32'h0, '1);
		bus(1'b1, 3'h5, '1);
		rd(3'h5, 32'h0, '1);
		r = rnd() & 32'h3f;
		bus(1'b1, REG_CTRL, r);
		rd(REG_CTRL, r, '1);
		bus(1'b1, REG_CTRL, 32'h0);
		grayscale_on_in <= '1;
		new_period();
		n = 0;
		while (sink_output_out[0] !== 1'b1 && n < 50)
		begin
			cyc(1);
			n++;
		end
		if (n == 50)
		begin
			miscompares++;
			end_of_test();
		end
		check({31'h0, sink_output_out[1]}, 32'h0);
		cyc(7);
		check({16'h0, sink_output_out}, 32'hffff);
		reference_current_pin_short_in <= 1'b1;
		st(32'h1 << ST_REF_BIT);
		reference_current_pin_short_in <= 1'b0;
		grayscale_on_in <= '0;
		st(32'h0);
		temp_warn_in <= 1'b1;
		st(32'h1 << ST_WARN_BIT);
		check({31'h0, thermal_warning_flag_out}, 32'h1);
		temp_warn_in <= 1'b0;
		strobe(1'b0);
		st(32'h1 << ST_WARN_BIT);
		strobe(1'b1);
		st(32'h0);
		grayscale_on_in <= '1;
		temp_over_in <= 1'b1;
		st(32'h1 << ST_TERR_BIT);
		temp_over_in <= 1'b0;
		temp_cool_in <= 1'b1;
		st(32'h1 << ST_TERR_BIT);
		strobe(1'b1);
		st(32'h0);
		check({16'h0, sink_output_out}, 32'h0);
		new_period();
		cyc(10);
		check({16'h0, sink_output_out}, 32'h0);
		new_period();
		cyc(10);
		check({16'h0, sink_output_out}, 32'hffff);
		grayscale_on_in <= '0;
		for (int c = 1; c <= 2; c++)
		begin
			bus(1'b1, REG_CTRL, 32'(c << CTRL_PS_LSB) | 32'h1);
			grayscale_zero_write_in <= 1'b1;
			cyc(1);
			grayscale_zero_write_in <= 1'b0;
			st(32'h1 << ST_PS_BIT);
			check({31'h0, power_save_state_out}, 32'h1);
			new_period();
			host.pwm_burst(4);
			host.sclk_edge();
			cyc(1);
			st(c == 1 ? 32'h0 : 32'h1 << ST_PS_BIT);
		end
		bus(1'b1, REG_CTRL, 32'h0);
		st(32'h0);
		for (int k = 0; k < 4; k++)
		begin
			r = rnd();
			{short_cmp_in, open_cmp_in} <= r;
			bus(1'b1, REG_CTRL, 32'(k << CTRL_LAT_LSB) | (r & 32'he) | 32'h1);
			cyc(8);
			new_period();
			host.pwm_burst(int'(lc[k]) - 1);
			cyc(10);
			check({16'h0, detect_sink_out}, 32'hffff);
			check({16'h0, leak_source_out}, 32'h0);
			check({29'h0, detection_current_select_out}, (r >> 1) & 32'h7);
			host.pwm_burst(3);
			cyc(10);
			check({16'h0, detect_sink_out}, 32'h0);
			rd(REG_DETECT, r, '1);
		end
		bus(1'b1, REG_CTRL, 32'h0);
		r = rnd();
		{short_cmp_in, open_cmp_in} <= r;
		leak_high_cmp_in <= r[31:16];
		cyc(8);
		new_period();
		host.pwm_burst(4);
		cyc(10);
		rd(REG_DETECT, 32'h0, '1);
		rd(REG_LEAK, {16'h0, ~r[31:16]}, '1);
		check({16'h0, leak_source_out}, 32'hffff);
		cyc(2);
		end_of_test();
	end
endmodule
